/* shared/pci_tgt_pkg.sv */
// Shared constants and types for the 64-bit bus target back end
`default_nettype none
package pci_tgt_pkg;

  // Register byte offsets on the APB side
  localparam logic [11:0] CTRL_OFS     = 12'h000;
  localparam logic [11:0] STATUS_OFS   = 12'h004;
  localparam logic [11:0] INT_STAT_OFS = 12'h008;
  localparam logic [11:0] INT_MASK_OFS = 12'h00C;
  localparam logic [11:0] BASE0_OFS    = 12'h010;
  localparam logic [11:0] BASE1_OFS    = 12'h014;

  // Control fields and reset value
  localparam int          CTRL_EN_BIT   = 0;
  localparam int          CTRL_WIDE_BIT = 1;
  localparam logic [1:0]  CTRL_RST      = 2'h2;
  localparam logic [31:0] BASE_RST      = 32'h0000_0000;

  // Event bits, shared by status and mask registers
  localparam int         EV_CLAIM = 0;
  localparam int         EV_ABORT = 1;
  localparam int         EV_RETRY = 2;
  localparam int         EV_DONE  = 3;
  localparam int         EV_W     = 4;
  localparam logic [3:0] INT_RST  = 4'h0;

  // Memory command codes on the low byte-enable lines
  localparam logic [3:0] CMD_MEM_RD     = 4'h6;
  localparam logic [3:0] CMD_MEM_WR     = 4'h7;
  localparam logic [3:0] CMD_MEM_RD_MUL = 4'hC;
  localparam logic [3:0] CMD_MEM_RD_LN  = 4'hE;
  localparam logic [3:0] CMD_MEM_WR_INV = 4'hF;

  // Clocks after the claim cycle before ready may be computed
  localparam logic [1:0] TRDY_LAT_WR = 2'h1;
  localparam logic [1:0] TRDY_LAT_RD = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_BUSY = 3'h1,
    ST_DATA = 3'h3,
    ST_TERM = 3'h2,
    ST_TURN = 3'h6
  } tstate_e;

  // Back-end controls into the target
  typedef struct packed {
    logic ready;
    logic term;
    logic abort;
  } bk_ctrl_s;

  // Back-end indications out of the target
  typedef struct packed {
    logic address_valid_strobe;
    logic target_write_direction;
    logic wide_cycle_flag;
    logic data_valid;
  } bk_ind_s;

endpackage
`default_nettype wire

/* core/bar_decode.sv */
// Address range compare for one base address range
`timescale 1ns/1ns
`default_nettype none
module bar_decode #(
  parameter int SIZE_BITS = 20
) (
  // Range setup
  input  wire logic [31:0] base_i,
  input  wire logic        enable_i,
  // Captured address
  input  wire logic [31:0] addr_i,
  // Result
  output logic             hit_o
);
  wire upper_match = (addr_i[31:SIZE_BITS] == base_i[31:SIZE_BITS]);

  assign hit_o = enable_i & upper_match;
endmodule // bar_decode
`default_nettype wire

/* core/pci_target_abort_backend.sv */
// Target transaction engine of a 64-bit bus interface with APB registers
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ns
`default_nettype none
// Operation
// R1: Initiator drives frame, 64-bit request, address and read-multiple command.
// R2: Initiator keeps frame low and asserts initiator-ready after the address phase.
// R3: Address-valid strobe one clock after address phase, address on shared bus.
// R4: Back end loads its address counter while the strobe is high.
// R5: Leaving idle goes through bus-busy, then into the data state.
// R6: Claim the transaction with medium decode timing on DEVSEL#.
// R7: One clock of latency between DEVSEL# and earliest TRDY#.
// R8: Reads hold off TRDY# one more clock for AD turnaround.
// R9: Base-hit bit of the matching range pulses for exactly one clock.
// R10: Write-direction indication is low during reads.
// R11: Wide-cycle flag rises with DEVSEL# and holds for the transfer.
// R12: Back end holds ready high and terminate low for a burst.
// R13: Back end raises abort on a serious error such as range overrun.
// R14: Edge after abort seen: STOP# asserted, TRDY# and DEVSEL# released.
// R15: Initiator releases frame on the next clock after target abort.
// R16: Abort wins regardless of ready and terminate levels.
// R17: Terminate with ready low gives a retry without data.
// R18: Back end holds abort until STOP#, releases before next claim.
module pci_target_abort_backend #(
  parameter int NUM_BARS  = 2,
  parameter int BAR_SIZE0 = 20,
  parameter int BAR_SIZE1 = 16
) (
  // Clock and reset
  input  wire logic                     mclk_i,
  input  wire logic                     rst_b_i,
  // Bus inputs
  input  wire logic                     frame_n_i,
  input  wire logic                     irdy_n_i,
  input  wire logic                     req64_n_i,
  input  wire logic [7:0]               cbe_n_i,
  input  wire logic [63:0]              ad_i,
  // Bus target outputs, enables low while driving
  output logic [63:0]                   ad_o,
  output logic                          ad_oe_n_o,
  output logic                          devsel_n_o,
  output logic                          trdy_n_o,
  output logic                          stop_n_o,
  output logic                          ack64_n_o,
  output logic                          ctl_oe_n_o,
  // Back end
  input  wire pci_tgt_pkg::bk_ctrl_s    backend_ctrl_i,
  input  wire logic [63:0]              read_data_i,
  output var pci_tgt_pkg::bk_ind_s      backend_ind_o,
  output logic [63:0]                   internal_shared_bus_o,
  output logic [7:0]                    base_hit_o,
  // APB slave
  input  wire logic                     psel_i,
  input  wire logic                     penable_i,
  input  wire logic                     pwrite_i,
  input  wire logic [11:0]              paddr_i,
  input  wire logic [31:0]              pwdata_i,
  output logic [31:0]                   prdata_o,
  output logic                          pready_o,
  output logic                          pslverr_o,
  // Interrupt
  output logic                          irq_o
);
  pci_tgt_pkg::tstate_e state_reg, state_next;

  logic                         frame_q_reg;
  logic [31:0]                  addr_reg;
  logic [3:0]                   cmd_reg;
  logic                         req64_reg;
  logic                         strobe_reg;
  logic [63:0]                  shared_reg;
  logic                         devsel_reg, trdy_reg, stop_reg, ack64_reg, ctl_oe_reg;
  logic                         wide_reg, abort_reg, data_done_reg, data_valid_reg;
  logic [1:0]                   lat_reg;
  logic [7:0]                   base_hit_reg;
  logic [63:0]                  ad_reg;
  logic                         ad_drive_reg;
  logic [1:0]                   ctrl_reg;
  logic [31:0]                  base_reg [NUM_BARS];
  logic [pci_tgt_pkg::EV_W-1:0] int_stat_reg, int_mask_reg;
  logic [31:0]                  prdata_reg;
  logic [NUM_BARS-1:0]          hits;

  // Address decode, one comparator per range
  for (genvar g = 0; g < NUM_BARS; g++) begin : g_bar
    bar_decode #(
      .SIZE_BITS (g == 0 ? BAR_SIZE0 : BAR_SIZE1)
    ) u_bar (
      .base_i   (base_reg[g]),
      .enable_i (ctrl_reg[pci_tgt_pkg::CTRL_EN_BIT]),
      .addr_i   (addr_reg),
      .hit_o    (hits[g])
    );
  end

  // Phase and decode terms
  wire cmd_wr     = cmd_reg[0];
  wire cmd_mem    = (cmd_reg == pci_tgt_pkg::CMD_MEM_RD) | (cmd_reg == pci_tgt_pkg::CMD_MEM_WR)
                  | (cmd_reg == pci_tgt_pkg::CMD_MEM_RD_MUL) | (cmd_reg == pci_tgt_pkg::CMD_MEM_RD_LN)
                  | (cmd_reg == pci_tgt_pkg::CMD_MEM_WR_INV);
  wire in_idle    = (state_reg == pci_tgt_pkg::ST_IDLE);
  wire in_busy    = (state_reg == pci_tgt_pkg::ST_BUSY);
  wire in_data    = (state_reg == pci_tgt_pkg::ST_DATA);
  wire in_term    = (state_reg == pci_tgt_pkg::ST_TERM);
  // Frame falling while idle marks the address phase
  wire addr_phase = in_idle & ~frame_n_i & frame_q_reg;
  wire enter_data = in_busy & cmd_mem & (|hits);
  wire xfer       = trdy_reg & ~irdy_n_i;
  wire last_xfer  = xfer & frame_n_i;
  wire [1:0] need = cmd_wr ? pci_tgt_pkg::TRDY_LAT_WR : pci_tgt_pkg::TRDY_LAT_RD;
  wire trdy_ok    = in_data & (lat_reg >= need); // [R7] [R8]
  wire abort_now  = in_data & backend_ctrl_i.abort; // [R16]
  wire term_now   = in_data & ~abort_now & ~last_xfer & backend_ctrl_i.term
                  & (~backend_ctrl_i.ready | trdy_ok);
  wire retry_now  = term_now & ~backend_ctrl_i.ready & ~data_done_reg; // [R17]
  wire term_exit  = in_term & frame_n_i & (~trdy_reg | xfer);
  wire data_exit  = in_data & (last_xfer | (frame_n_i & irdy_n_i));
  wire abort_next = abort_reg | abort_now;

  always_comb begin
    case (state_reg)
      pci_tgt_pkg::ST_IDLE: state_next = addr_phase ? pci_tgt_pkg::ST_BUSY : pci_tgt_pkg::ST_IDLE; // [R5]
      pci_tgt_pkg::ST_BUSY: state_next = enter_data ? pci_tgt_pkg::ST_DATA : pci_tgt_pkg::ST_IDLE; // [R5] [R6]
      pci_tgt_pkg::ST_DATA: begin
        if (abort_now | term_now) begin
          state_next = pci_tgt_pkg::ST_TERM; // [R14]
        end else if (data_exit) begin
          state_next = pci_tgt_pkg::ST_TURN;
        end else begin
          state_next = pci_tgt_pkg::ST_DATA;
        end
      end
      pci_tgt_pkg::ST_TERM: state_next = term_exit ? pci_tgt_pkg::ST_TURN : pci_tgt_pkg::ST_TERM;
      pci_tgt_pkg::ST_TURN: state_next = pci_tgt_pkg::ST_IDLE;
      default:              state_next = pci_tgt_pkg::ST_IDLE;
    endcase
  end

  wire nx_data = (state_next == pci_tgt_pkg::ST_DATA);
  wire nx_term = (state_next == pci_tgt_pkg::ST_TERM);
  wire nx_idle = (state_next == pci_tgt_pkg::ST_IDLE);
  // Abort drops DEVSEL# at once; retry and disconnect keep it
  wire devsel_next = nx_data | (nx_term & ~abort_next); // [R6] [R14]
  wire trdy_next   = (in_data & nx_data & trdy_ok & backend_ctrl_i.ready)
                   | (term_now & backend_ctrl_i.ready)
                   | (in_term & nx_term & trdy_reg & ~xfer); // [R14] [R16]
  wire wide_next   = enter_data ? (req64_reg & ctrl_reg[pci_tgt_pkg::CTRL_WIDE_BIT])
                   : (nx_idle ? 1'b0 : wide_reg); // [R11]
  wire [pci_tgt_pkg::EV_W-1:0] events = {(state_next == pci_tgt_pkg::ST_TURN) & ~in_busy, retry_now,
                                         abort_now, enter_data};

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg   <= pci_tgt_pkg::ST_IDLE;
      frame_q_reg <= 1'b1;
      addr_reg    <= 32'h0000_0000;
      cmd_reg     <= 4'h0;
      req64_reg   <= 1'b0;
      strobe_reg  <= 1'b0;
    end else begin
      state_reg   <= state_next;
      frame_q_reg <= frame_n_i;
      strobe_reg  <= addr_phase; // [R3]
      if (addr_phase) begin
        addr_reg  <= ad_i[31:0];
        cmd_reg   <= cbe_n_i[3:0];
        req64_reg <= ~req64_n_i;
      end
    end
  end

  // Target control outputs, all registered
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      devsel_reg <= 1'b0;
      trdy_reg   <= 1'b0;
      stop_reg   <= 1'b0;
      ack64_reg  <= 1'b0;
      ctl_oe_reg <= 1'b0;
      wide_reg   <= 1'b0;
      abort_reg  <= 1'b0;
    end else begin
      devsel_reg <= devsel_next;
      trdy_reg   <= trdy_next;
      stop_reg   <= nx_term; // [R14] [R17]
      ack64_reg  <= devsel_next & wide_next;
      ctl_oe_reg <= nx_data | nx_term | (state_next == pci_tgt_pkg::ST_TURN);
      wide_reg   <= wide_next;
      abort_reg  <= nx_idle ? 1'b0 : abort_next;
    end
  end

  // Back-end side: latency count, hit pulse, data path
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lat_reg        <= 2'h0;
      base_hit_reg   <= 8'h00;
      data_done_reg  <= 1'b0;
      data_valid_reg <= 1'b0;
      shared_reg     <= 64'h0000_0000_0000_0000;
      ad_reg         <= 64'h0000_0000_0000_0000;
      ad_drive_reg   <= 1'b0;
    end else begin
      if (enter_data) begin
        lat_reg <= 2'h0;
      end else if (in_data && lat_reg != 2'h3) begin
        lat_reg <= lat_reg + 2'h1;
      end
      base_hit_reg   <= enter_data ? 8'(hits) : 8'h00; // [R9]
      data_done_reg  <= enter_data ? 1'b0 : (data_done_reg | xfer);
      data_valid_reg <= xfer;
      if (addr_phase || (xfer && cmd_wr)) begin
        shared_reg <= ad_i; // [R3]
      end
      if (!trdy_reg || xfer) begin
        ad_reg <= read_data_i;
      end
      // Turnaround: AD is not driven in the claim cycle of a read
      ad_drive_reg <= ~cmd_wr & ((nx_data & in_data) | nx_term); // [R8]
    end
  end

  assign devsel_n_o            = ~devsel_reg;
  assign trdy_n_o              = ~trdy_reg;
  assign stop_n_o              = ~stop_reg;
  assign ack64_n_o             = ~ack64_reg;
  assign ctl_oe_n_o            = ~ctl_oe_reg;
  assign ad_o                  = ad_reg;
  assign ad_oe_n_o             = ~ad_drive_reg;
  assign internal_shared_bus_o = shared_reg;
  assign base_hit_o            = base_hit_reg;
  assign backend_ind_o.address_valid_strobe   = strobe_reg;
  assign backend_ind_o.target_write_direction = cmd_wr; // [R10]
  assign backend_ind_o.wide_cycle_flag        = wide_reg; // [R11]
  assign backend_ind_o.data_valid             = data_valid_reg;

  // APB decode; zero wait states, read data loaded in the setup cycle
  wire setup      = psel_i & ~penable_i;
  wire wr_access  = psel_i & penable_i & pwrite_i;
  wire sel_ctrl   = (paddr_i == pci_tgt_pkg::CTRL_OFS);
  wire sel_status = (paddr_i == pci_tgt_pkg::STATUS_OFS);
  wire sel_istat  = (paddr_i == pci_tgt_pkg::INT_STAT_OFS);
  wire sel_imask  = (paddr_i == pci_tgt_pkg::INT_MASK_OFS);
  wire sel_base0  = (paddr_i == pci_tgt_pkg::BASE0_OFS);
  wire sel_base1  = (paddr_i == pci_tgt_pkg::BASE1_OFS);
  wire mapped     = sel_ctrl | sel_status | sel_istat | sel_imask | sel_base0 | sel_base1;
  wire [31:0] status_word = {22'h00_0000, base_hit_reg[1:0], abort_reg, wide_reg, cmd_wr,
                             devsel_reg, 1'b0, state_reg};
  wire [31:0] rd_mux = sel_ctrl   ? {30'h0000_0000, ctrl_reg}
                     : sel_status ? status_word
                     : sel_istat  ? {28'h000_0000, int_stat_reg}
                     : sel_imask  ? {28'h000_0000, int_mask_reg}
                     : sel_base0  ? base_reg[0]
                     : sel_base1  ? base_reg[1]
                     : 32'h0000_0000;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_reg     <= pci_tgt_pkg::CTRL_RST;
      int_mask_reg <= pci_tgt_pkg::INT_RST;
      prdata_reg   <= 32'h0000_0000;
      for (int i = 0; i < NUM_BARS; i++) begin
        base_reg[i] <= pci_tgt_pkg::BASE_RST;
      end
    end else begin
      if (setup) begin
        prdata_reg <= rd_mux;
      end
      if (wr_access && sel_ctrl) begin
        ctrl_reg <= pwdata_i[1:0];
      end
      if (wr_access && sel_imask) begin
        int_mask_reg <= pwdata_i[pci_tgt_pkg::EV_W-1:0];
      end
      if (wr_access && sel_base0) begin
        base_reg[0] <= pwdata_i;
      end
      if (wr_access && sel_base1) begin
        base_reg[1] <= pwdata_i;
      end
    end
  end

  // Sticky events: a new event wins over a write-one clear
  wire [pci_tgt_pkg::EV_W-1:0] w1c = (wr_access & sel_istat) ? pwdata_i[pci_tgt_pkg::EV_W-1:0] : 4'h0;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      int_stat_reg <= pci_tgt_pkg::INT_RST;
    end else begin
      int_stat_reg <= (int_stat_reg & ~w1c) | events;
    end
  end

  assign irq_o     = |(int_stat_reg & int_mask_reg);
  assign prdata_o  = prdata_reg;
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~mapped;

  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  addr_strobe_a: assert property (addr_phase |=> strobe_reg && shared_reg == $past(ad_i)) // [R3]
    else $error("address strobe or shared bus wrong after address phase");
  busy_state_a: assert property (addr_phase |=> in_busy ##1 (in_data || in_idle)) // [R5]
    else $error("busy step skipped");
  devsel_medium_a: assert property ($rose(devsel_reg) |-> $past(state_reg) == pci_tgt_pkg::ST_BUSY
                                    && $past(state_reg, 2) == pci_tgt_pkg::ST_IDLE) // [R6]
    else $error("claim not at medium decode timing");
  trdy_gap_a: assert property ($rose(devsel_reg) |-> !trdy_reg ##1 !trdy_reg) // [R7]
    else $error("ready too soon after claim");
  read_turn_a: assert property ($rose(devsel_reg) && !cmd_wr |-> !trdy_reg [*3]) // [R8]
    else $error("read ready inside turnaround");
  hit_pulse_a: assert property ($rose(devsel_reg) |-> base_hit_o != 8'h00 ##1 base_hit_o == 8'h00) // [R9]
    else $error("base hit not a single pulse");
  read_dir_a: assert property (devsel_reg && cmd_reg == pci_tgt_pkg::CMD_MEM_RD_MUL
                               |-> !backend_ind_o.target_write_direction) // [R10]
    else $error("direction high on a read");
  wide_hold_a: assert property (wide_reg && !nx_idle |=> wide_reg) // [R11]
    else $error("wide flag dropped mid transfer");
  abort_stop_a: assert property (in_data && backend_ctrl_i.abort |=> stop_reg && !trdy_reg && !devsel_reg) // [R14]
    else $error("abort not signalled on next edge");
  abort_wins_a: assert property (abort_now && backend_ctrl_i.ready && !backend_ctrl_i.term
                                 |=> in_term ##1 !devsel_reg) // [R16]
    else $error("abort lost to ready");
  retry_a: assert property (retry_now && !abort_now |=> stop_reg && devsel_reg && !trdy_reg) // [R17]
    else $error("retry not signalled");

  abort_c: cover property (in_data && backend_ctrl_i.abort ##1 in_term ##[1:8] in_idle);
  retry_c: cover property (retry_now ##1 stop_reg);
  read_done_c: cover property (enter_data && !cmd_wr ##[1:20] last_xfer);
  disconnect_c: cover property (term_now && backend_ctrl_i.ready);
endmodule // pci_target_abort_backend
`default_nettype wire

/* bench/pci_partner.sv */
// Initiator and back-end model on the far side of the target engine
`timescale 1ns/1ns
`default_nettype none
module pci_partner (
  // Clock and target outputs as seen on the wires
  input  wire logic                 mclk_i,
  input  wire logic                 devsel_n_i,
  input  wire logic                 trdy_n_i,
  input  wire logic                 stop_n_i,
  input  wire logic                 ctl_oe_n_i,
  input  wire logic [7:0]           base_hit_i,
  input  wire pci_tgt_pkg::bk_ind_s ind_i,
  input  wire logic [63:0]          isb_i,
  // Initiator and back-end drive
  output logic                      frame_n_o,
  output logic                      irdy_n_o,
  output logic                      req64_n_o,
  output logic [7:0]                cbe_n_o,
  output logic [63:0]               ad_o,
  output var pci_tgt_pkg::bk_ctrl_s ctrl_o,
  output logic [63:0]               rdata_o
);
  logic [63:0] addr_hold;
  logic [63:0] ad_idle;
  logic [63:0] addr_cnt;
  logic        ad_drive;
  int          ph;

  // Released bus toggles so a stale address never looks valid
  assign ad_o = ad_drive ? addr_hold : ad_idle;
  always @(posedge mclk_i) ad_idle <= ~ad_idle;
  always @(posedge mclk_i) rdata_o <= rdata_o + 64'h0101_0101_0101_0101;
  always @(posedge mclk_i) if (ind_i.address_valid_strobe === 1'b1) addr_cnt <= isb_i;

  initial begin
    frame_n_o = 1'b1;
    irdy_n_o  = 1'b1;
    req64_n_o = 1'b1;
    cbe_n_o   = 8'hFF;
    ctrl_o    = '0;
    rdata_o   = 64'h0;
    ad_idle   = 64'hA5A5_0F0F_3C3C_9696;
    addr_hold = 64'h0;
    addr_cnt  = 64'h0;
    ad_drive  = 1'b0;
  end

  // Mode 0 burst ended by terminate, 1 retry, 2 abort, 3 abort over terminate, 4 unclaimed, 5 initiator ends
  task automatic xfer(input logic [3:0] cmd, input logic [31:0] addr, input int mode, output int res[11]);
    res = '{default: 0};
    ph  = 0;
    @(posedge mclk_i);
    frame_n_o <= 1'b0;
    req64_n_o <= 1'b0;
    cbe_n_o   <= {4'h0, cmd};
    addr_hold <= {32'h0, addr};
    ad_drive  <= 1'b1;
    for (int k = 1; k < 40; k++) begin
      @(posedge mclk_i);
      if (k == 1) begin
        irdy_n_o     <= 1'b0;
        cbe_n_o      <= 8'h00;
        // Writes keep AD driven with a data word tied to the address
        ad_drive     <= cmd[0];
        addr_hold    <= {32'h0, addr ^ 32'h0000_5A5A};
        ctrl_o.ready <= (mode != 1);
        ctrl_o.term  <= (mode == 1);
      end
      if (k == 4 && (mode == 2 || mode == 3)) begin
        ctrl_o.abort <= 1'b1;
        ctrl_o.ready <= (mode == 2);
        ctrl_o.term  <= (mode == 3);
      end
      if (k == 6 && mode == 0) ctrl_o.term <= 1'b1;
      if (ph == 1) begin
        irdy_n_o <= 1'b1;
        cbe_n_o  <= 8'hFF;
        ctrl_o   <= '0;
        ad_drive <= 1'b0;
        ph = 2;
      end
      if (ph == 0 && (res[3] != 0 || (mode >= 4 && k == 6))) begin
        frame_n_o <= 1'b1;
        req64_n_o <= 1'b1;
        ph = 1;
      end
      #1;
      if (ph == 2 && ctl_oe_n_i === 1'b1) break;
      if (ind_i.address_valid_strobe === 1'b1 && res[0] == 0) res[0] = k;
      if (devsel_n_i === 1'b0 && res[1] == 0) res[1] = k;
      if (trdy_n_i === 1'b0 && res[2] == 0) res[2] = k;
      if (ind_i.data_valid === 1'b1) begin
        res[9]++;
        if (res[10] == 0) res[10] = isb_i[31:0];
      end
      if (stop_n_i === 1'b0 && res[3] == 0) begin
        res[3] = k;
        res[7] = devsel_n_i;
      end
      if (base_hit_i != 8'h00) begin
        res[4]++;
        res[5] = base_hit_i;
      end
      if (devsel_n_i === 1'b0) begin
        res[6] = ind_i.target_write_direction;
        res[8] |= (ind_i.wide_cycle_flag === 1'b1) ? 1 : 2;
      end
    end
  endtask
endmodule  // pci_partner
`default_nettype wire

/* bench/tb_top.sv */
// Self-checking bench for the bus target engine
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic                  mclk, rst_b, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0]           paddr;
  logic [31:0]           pwdata, prdata;
  logic                  frame_n, irdy_n, req64_n, ad_oe_n, devsel_n, trdy_n, stop_n, ctl_oe_n;
  logic                  ack64_n, wide_exp;
  logic [7:0]            cbe_n, base_hit;
  logic [63:0]           p_ad, d_ad, isb, rdata;
  logic [3:0]            mask;
  logic [15:0]           rnd;
  pci_tgt_pkg::bk_ctrl_s ctrl;
  pci_tgt_pkg::bk_ind_s  ind;
  logic [32:0]           apb_q[$];
  logic [63:0]           addr_q[$];
  logic [3:0]            cmds[5] = '{4'h6, 4'h7, 4'hC, 4'hE, 4'hF};
  int                    mismatches = 0;
  int                    samples_checked = 0;

  pci_target_abort_backend i_dut (
    .mclk_i(mclk), .rst_b_i(rst_b), .frame_n_i(frame_n), .irdy_n_i(irdy_n), .req64_n_i(req64_n),
    .cbe_n_i(cbe_n), .ad_i(ad_oe_n ? p_ad : d_ad), .ad_o(d_ad), .ad_oe_n_o(ad_oe_n),
    .devsel_n_o(devsel_n), .trdy_n_o(trdy_n), .stop_n_o(stop_n), .ack64_n_o(ack64_n), .ctl_oe_n_o(ctl_oe_n),
    .backend_ctrl_i(ctrl), .read_data_i(rdata), .backend_ind_o(ind), .internal_shared_bus_o(isb),
    .base_hit_o(base_hit), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq)
  );

  // Released control lines read high through their pull-ups
  pci_partner i_partner (
    .mclk_i(mclk), .devsel_n_i(ctl_oe_n ? 1'b1 : devsel_n), .trdy_n_i(ctl_oe_n ? 1'b1 : trdy_n),
    .stop_n_i(ctl_oe_n ? 1'b1 : stop_n), .ctl_oe_n_i(ctl_oe_n), .base_hit_i(base_hit), .ind_i(ind),
    .isb_i(isb), .frame_n_o(frame_n), .irdy_n_o(irdy_n), .req64_n_o(req64_n), .cbe_n_o(cbe_n),
    .ad_o(p_ad), .ctrl_o(ctrl), .rdata_o(rdata)
  );

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %0h, expected %0h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("Mismatches %0d, comparisons %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] exp);
    apb_q.push_back(exp);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic chk_irq(input logic e);
    @(negedge mclk);
    chk(irq, e);
  endtask

  task automatic run(input logic [3:0] cmd, input int bar, input int mode, input logic wide);
    logic [31:0] a;
    logic [3:0]  st;
    int          res[11];
    rnd = lfsr(rnd);
    a   = {8'h00, 4'(bar + 1), 4'h0, rnd & 16'hFFF8};
    st  = (mode == 4) ? 4'h0 : {1'b1, mode == 1, mode == 2 || mode == 3, 1'b1};
    apb(1'b1, 12'h000, {30'h0, wide, 1'b1});
    wide_exp <= wide;
    addr_q.push_back({32'h0, a});
    i_partner.xfer(cmd, a, mode, res);
    chk(res[0], 1);
    chk(i_partner.addr_cnt, {32'h0, a});
    chk(res[1], mode == 4 ? 0 : 2);
    chk(res[4], mode == 4 ? 0 : 1);
    if (mode != 4) begin
      chk(res[5], bar + 1);
      chk(res[6], cmd[0]);
      chk(res[8], wide ? 1 : 2);
    end
    if (mode == 0 || mode == 5) begin
      chk(res[2], cmd[0] ? 4 : 5);
      chk(res[3], mode == 0 ? 7 : 0);
      chk(res[9], (mode == 0 ? 3 : 2) + cmd[0]);
      chk(res[10], cmd[0] ? a ^ 32'h0000_5A5A : a);
    end
    if (mode == 1) begin
      chk(res[2], 0);
      chk(res[9], 0);
      chk(res[3], 3);
      chk(res[7], 0);
    end
    if (mode == 2 || mode == 3) begin
      chk(res[2], 0);
      chk(res[9], 0);
      chk(res[3], 5);
      chk(res[7], 1);
    end
    chk_irq((st & mask) != 4'h0);
    rd(12'h008, {29'h0, st});
    apb(1'b1, 12'h008, 32'h0000_000F);
    chk_irq(1'b0);
  endtask

  // Reads and address strobes are matched against the oldest note
  always @(posedge mclk) begin
    if (psel && penable && pready && !pwrite) chk({31'h0, pslverr, prdata}, {31'h0, apb_q.pop_front()});
    if (ind.address_valid_strobe === 1'b1) chk(isb, addr_q.pop_front());
    if (ctl_oe_n === 1'b0) chk(ack64_n, devsel_n | !wide_exp);
  end

  initial begin
    rst_b   = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    rnd     = 16'h5D1F;
    mask    = 4'hF;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    rd(12'h000, 33'h0_0000_0002);
    for (int i = 1; i < 6; i++) rd(12'(4 * i), 33'h0);
    rd(12'h018, 33'h1_0000_0000);
    apb(1'b1, 12'h018, 32'hFFFF_FFFF);
    apb(1'b1, 12'h010, 32'h0010_0000);
    apb(1'b1, 12'h014, 32'h0020_0000);
    apb(1'b1, 12'h00C, 32'h0000_000F);
    rd(12'h014, 33'h0_0020_0000);
    rd(12'h00C, 33'h0_0000_000F);
    run(4'hC, 0, 2, 1'b1);
    run(4'hC, 1, 3, 1'b0);
    run(4'hE, 0, 1, 1'b1);
    foreach (cmds[i]) run(cmds[i], i % 2, 0, i % 2 == 0);
    // Initiator ends the burst itself, no stop
    run(4'h7, 1, 5, 1'b0);
    run(4'hC, 0, 5, 1'b1);
    run(4'hC, 2, 4, 1'b1);
    run(4'h2, 0, 4, 1'b1);
    // Masking: retry only shows when its own bit is enabled
    for (int m = 1; m < 3; m++) begin
      mask = 4'(8 >> m);
      apb(1'b1, 12'h00C, {28'h0, mask});
      run(4'hE, 1, 1, 1'b1);
    end
    rd(12'h004, 33'h0);
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    $display("CHECK FAILED at %0t: run timed out", $time);
    print_verdict();
  end
endmodule  // tb_top
`default_nettype wire
